// ### core_seq_model.sv
/*
 * Behavioural program sequencer that issues instruction words to the block.
 * Assumes the bench requests one word per cycle on issue, with gaps allowed.
 */
`timescale 1ns/10ps
module core_seq_model
    import skip_ext1_pkg::*;
(
    input  wire logic               mclk,                 // Core clock
    input  wire logic               issue,                // Bench asks for a word
    input  wire logic [INSTR_W-1:0] code_in,              // Word to issue
    output logic                    instr_valid = 1'h0,   // Word issued
    output logic [INSTR_W-1:0]      instr_code = 10'h000  // Issued word
);
    // Idle cycles show a changing pattern so a stale word is never mistaken for a valid one
    always_ff @(posedge mclk)
    begin
        instr_valid <= issue;
        instr_code  <= issue ? code_in : ~instr_code;
    end
endmodule

// ### decode_if.sv
/*
 * Carrier between the skip test core and its opcode decoder.
 * Assumes both ends sit in the same clock domain.
 */
`timescale 1ns/10ps
interface decode_if;
    import skip_ext1_pkg::*;

    logic [INSTR_W-1:0] code;
    logic               hit;

    modport dec
    (
        input  code,
        output hit
    );

    modport core
    (
        output code,
        input  hit
    );
endinterface

// ### ext1_flag_skip_test.sv
/*
 * Execute logic for the skip_if_ext1_request instruction, including the
 * ext1_request_flag it tests and clears, and the skip of the next word.
 * Assumes the sequencer presents one instruction per instr_valid cycle and
 * honours skip_next and squash; the enable bit comes from
 * interrupt_control_reg_a outside this block.
 */
`timescale 1ns/10ps
module ext1_flag_skip_test
    import skip_ext1_pkg::*;
(
    input  wire logic               mclk,                       // 25 MHz core clock
    input  wire logic               srst,                       // Sync reset, active high
    input  wire logic               instr_valid,                // Instruction issued
    input  wire logic [INSTR_W-1:0] instr_code,                 // Issued instruction word
    input  wire logic               ext1_interrupt_enable_bit,  // External-1 enable
    input  wire logic               ext1_request_set,           // External-1 event pulse
    output logic                    ext1_request_flag,          // Request flag state
    output logic                    skip_next,                  // Skip taken, one pulse
    output logic                    test_done,                  // Test executed, one pulse
    output logic                    squash                      // Issued word is skipped
);

    decode_if dec_bus ();

    skip_ext1_decoder u_dec
    (
        .dec (dec_bus.dec)
    );

    seq_state_e state_reg;
    seq_state_e state_next;
    logic       flag_reg;
    logic       flag_next;
    logic       skip_reg;
    logic       skip_next_val;
    logic       done_reg;
    logic       done_next;
    logic       exec;
    logic       test_hit;
    logic       take_skip;
    logic       clear_flag;

    assign dec_bus.code = instr_code;

    // A word issued while a skip is pending is discarded, so it never
    // reaches the decoder's consequences even if it is another test.
    assign squash   = instr_valid && (state_reg == SEQ_SKIP);
    assign exec     = instr_valid && (state_reg == SEQ_RUN);
    assign test_hit = exec && dec_bus.hit;

    always_comb
    begin
        take_skip  = 1'b0;
        clear_flag = 1'b0;
        if (test_hit && !ext1_interrupt_enable_bit && flag_reg)
        begin
            take_skip  = 1'b1;
            clear_flag = 1'b1;
        end
        else if (test_hit && ext1_interrupt_enable_bit)
        begin
            take_skip  = 1'b0;
            clear_flag = 1'b0;
        end
        else
        begin
            take_skip  = 1'b0;
            clear_flag = 1'b0;
        end
    end

    always_comb
    begin
        // A new event in the clearing cycle wins, so no request is lost
        if (ext1_request_set)
        begin
            flag_next = 1'b1;
        end
        else if (clear_flag)
        begin
            flag_next = 1'b0;
        end
        else
        begin
            flag_next = flag_reg;
        end
    end

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            SEQ_RUN:
            begin
                if (take_skip)
                begin
                    state_next = SEQ_SKIP;
                end
            end
            SEQ_SKIP:
            begin
                if (instr_valid)
                begin
                    state_next = SEQ_RUN;
                end
            end
            default:
            begin
                state_next = SEQ_RUN;
            end
        endcase
    end

    always_comb
    begin
        skip_next_val = take_skip;
        // Single-cycle completion; carry is never written from here
        done_next     = test_hit;
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            state_reg <= SEQ_RUN;
            flag_reg  <= FLAG_RESET_VALUE;
            skip_reg  <= 1'b0;
            done_reg  <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            flag_reg  <= flag_next;
            skip_reg  <= skip_next_val;
            done_reg  <= done_next;
        end
    end

    assign ext1_request_flag = flag_reg;
    assign skip_next         = skip_reg;
    assign test_done         = done_reg;

    // Checker-only record of a taken skip still waiting for its word; kept apart
    // from state_reg so the squash check does not lean on what it checks
    logic       chk_pend_reg;
    logic       chk_pend_next;

    always_comb
    begin
        if (chk_pend_reg)
        begin
            chk_pend_next = !instr_valid;
        end
        else
        begin
            chk_pend_next = instr_valid && (instr_code == OPC_SKIP_EXT1)
                            && !ext1_interrupt_enable_bit && flag_reg;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            chk_pend_reg <= 1'b0;
        end
        else
        begin
            chk_pend_reg <= chk_pend_next;
        end
    end

    sequence s_test;
        instr_valid && (state_reg == SEQ_RUN) && (instr_code == OPC_SKIP_EXT1);
    endsequence

    sequence s_skip_cause;
        s_test ##0 (!ext1_interrupt_enable_bit && flag_reg);
    endsequence

    sequence s_skip_result;
        skip_next && test_done && (state_reg == SEQ_SKIP);
    endsequence

    property p_decode;
        @(posedge mclk) disable iff (srst)
        exec |-> (dec_bus.hit == (instr_code == 10'h039));
    endproperty
    a_decode: assert property (p_decode)
        else $error("decoder match disagrees with opcode 039");

    property p_skip;
        @(posedge mclk) disable iff (srst)
        s_skip_cause |=> s_skip_result;
    endproperty
    a_skip: assert property (p_skip)
        else $error("skip not taken with enable 0 and flag 1");

    property p_squash_next;
        @(posedge mclk) disable iff (srst)
        instr_valid |-> (squash == chk_pend_reg);
    endproperty
    a_squash_next: assert property (p_squash_next)
        else $error("word after a taken skip was not squashed");

    property p_clear;
        @(posedge mclk) disable iff (srst)
        (s_skip_cause ##0 !ext1_request_set) |=> !ext1_request_flag;
    endproperty
    a_clear: assert property (p_clear)
        else $error("request flag not cleared after skip");

    property p_set_wins;
        @(posedge mclk) disable iff (srst)
        ext1_request_set |=> ext1_request_flag;
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("request event lost");

    property p_nop;
        @(posedge mclk) disable iff (srst)
        (s_test ##0 ext1_interrupt_enable_bit)
            |=> !skip_next && test_done
                && (ext1_request_flag == ($past(flag_reg) || $past(ext1_request_set)))
                && (state_reg == SEQ_RUN);
    endproperty
    a_nop: assert property (p_nop)
        else $error("test with enable 1 was not a no-op");

    property p_normal;
        @(posedge mclk) disable iff (srst)
        (s_test ##0 (!ext1_interrupt_enable_bit && !flag_reg))
            |=> test_done && !skip_next && (state_reg == SEQ_RUN);
    endproperty
    a_normal: assert property (p_normal)
        else $error("flag 0 test did not fall through in one cycle");

    property p_no_stray_skip;
        @(posedge mclk) disable iff (srst)
        skip_next |-> $past(test_hit) && !$past(ext1_interrupt_enable_bit);
    endproperty
    a_no_stray_skip: assert property (p_no_stray_skip)
        else $error("skip without an enabled-0 test");

endmodule

// ### ext1_flag_skip_test_tb.sv
/*
 * Self-checking bench for the external-1 flag skip test, with a reference model.
 * Assumes the sequencer model feeds the words and the bench drives the rest.
 */
`timescale 1ns/10ps
module ext1_flag_skip_test_tb;
    import skip_ext1_pkg::*;
    logic               mclk = 1'h0;
    logic               srst = 1'h1;
    logic               issue = 1'h0;
    logic [INSTR_W-1:0] code_in = 10'h000;
    logic               en = 1'h0;
    logic               set = 1'h0;
    wire logic          vld;
    wire logic [9:0]    code;
    wire logic          flag;
    wire logic          skip;
    wire logic          done;
    wire logic          sq;
    int                 err_count = 0;
    int                 checked = 0;
    logic [31:0]        lfsr = 32'h415E;
    logic               take;
    logic               m_flag = 1'h0;
    logic               m_pend = 1'h0;
    logic               m_done = 1'h0;
    logic               m_skip = 1'h0;

    always #20 mclk = ~mclk;

    core_seq_model seq (.mclk(mclk), .issue(issue), .code_in(code_in),
                        .instr_valid(vld), .instr_code(code));

    ext1_flag_skip_test dut (.mclk(mclk), .srst(srst), .instr_valid(vld), .instr_code(code),
                             .ext1_interrupt_enable_bit(en), .ext1_request_set(set),
                             .ext1_request_flag(flag), .skip_next(skip), .test_done(done),
                             .squash(sq));

    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        lfsr_next = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    task automatic chk(input logic got, input logic exp);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic print_verdict;
        $display("checks=%0d errors=%0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Reference model; reads the values that stood before this edge
    always @(posedge mclk)
    begin
        if (srst)
        begin
            {m_flag, m_pend, m_done, m_skip} = 4'h0;
        end
        else
        begin
            take   = vld && !m_pend && code == 10'h039;
            m_done = take;
            m_skip = take && !en && m_flag;
            m_pend = m_skip | (m_pend & !vld);
            m_flag = set | (m_flag & !m_skip);
        end
    end

    always @(negedge mclk)
    begin
        chk(flag, m_flag);
        chk(skip, m_skip);
        chk(done, m_done);
        if (!srst)
            chk(sq, vld & m_pend);
    end

    initial
    begin
        repeat (6) @(posedge mclk);
        srst <= 1'h0;
        for (int i = 0; i < 3000; i++)
        begin
            @(posedge mclk);
            lfsr = lfsr_next(lfsr);
            issue   <= lfsr[0] | lfsr[1];
            code_in <= (lfsr[4:2] != 3'h0) ? 10'h039 : lfsr[14:5];
            en      <= lfsr[15] & lfsr[16];
            set     <= lfsr[17] & lfsr[18] & lfsr[19];
            srst    <= (i == 1500);
        end
        print_verdict();
    end

    // Run needs about 3000 cycles; allow a wide margin before giving up
    initial
    begin
        #(40 * 4000);
        err_count++;
        print_verdict();
    end
endmodule

// ### skip_ext1_decoder.sv
/*
 * Opcode decoder for the external-1 request flag skip test.
 * Assumes the code on the carrier is stable for the issuing cycle.
 */
`timescale 1ns/10ps
module skip_ext1_decoder
    import skip_ext1_pkg::*;
(
    decode_if.dec dec  // Code in, match out
);

    always_comb
    begin
        dec.hit = is_skip_ext1(dec.code);
    end

endmodule

// ### skip_ext1_pkg.sv
/*
 * Shared constants and types for the external-1 request flag skip test.
 * Assumes a 10-bit instruction word and a single-clock core sequencer.
 */
package skip_ext1_pkg;

    localparam int          INSTR_W           = 10;
    localparam logic [9:0]  OPC_SKIP_EXT1     = 10'h039;
    localparam logic        FLAG_RESET_VALUE  = 1'h0;
    localparam int          TEST_WORDS        = 1;
    localparam int          TEST_CYCLES       = 1;

    typedef enum logic
    {
        SEQ_RUN,
        SEQ_SKIP
    } seq_state_e;

    function automatic logic is_skip_ext1(input logic [INSTR_W-1:0] code);
        is_skip_ext1 = (code == OPC_SKIP_EXT1);
    endfunction

endpackage
